// file: logic/tal_pkg.sv
package tal_pkg;

	// Channel layout, index equals alert mask bit position
	localparam int NCH = 8;
	localparam int IDX_R5 = 4;
	localparam int IDX_R6 = 5;
	localparam int IDX_LOCAL = 6;

	// Register offsets
	localparam logic [7:0] REG_TEMP_BASE = 8'h00;
	localparam logic [7:0] REG_HIGH_BASE = 8'h10;
	localparam logic [7:0] REG_LOW = 8'h18;
	localparam logic [7:0] REG_OVT_BASE = 8'h20;
	localparam logic [7:0] REG_CONFIG = 8'h41;
	localparam logic [7:0] REG_ALERT_MASK = 8'h42;
	localparam logic [7:0] REG_OVT_MASK = 8'h43;
	localparam logic [7:0] REG_STAT_ALERT = 8'h44;
	localparam logic [7:0] REG_STAT_OVT = 8'h45;
	localparam logic [7:0] REG_STAT_FAULT = 8'h46;
	localparam logic [7:0] REG_EXT_R5 = 8'h55;
	localparam logic [7:0] REG_EXT_R6 = 8'h56;
	localparam logic [7:0] REG_EXT_LOCAL = 8'h57;

	// Field positions and reset values
	localparam int CFG_STOP_BIT = 7;
	localparam logic [7:0] HIGH_RST = 8'h5a;
	localparam logic [7:0] LOW_RST = 8'h00;
	localparam logic [7:0] OVT_RST = 8'h6e;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'h00;
	localparam logic [7:0] EXT_RST = 8'h00;
	localparam logic [7:0] FAULT_TEMP = 8'hff;
	localparam logic [7:0] OVT_HYST = 8'h04;
	localparam logic [6:0] ARA_ADDR = 7'h19;

	// Diode fault qualification time
	localparam int CLK_FREQ_MHZ = 100;
	localparam int FAULT_TIME_US = 4000;
	localparam int FAULT_CYC = FAULT_TIME_US * CLK_FREQ_MHZ;

	typedef enum logic [6:0] {
		SMB_IDLE = 7'h01,
		SMB_ADDR = 7'h02,
		SMB_ACKA = 7'h04,
		SMB_RX = 7'h08,
		SMB_ACKR = 7'h10,
		SMB_TX = 7'h20,
		SMB_TXACK = 7'h40
	} tal_smb_st_t;

	typedef enum logic [1:0] {
		SEQ_START = 2'h1,
		SEQ_WAIT = 2'h2
	} tal_seq_t;

endpackage

// file: logic/tal_reg_if.sv
interface tal_reg_if;
	logic [7:0] ptr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic wr;
	logic rd;
	logic ara_armed;
	logic ara_done;

	modport smb (output ptr, output wdata, output wr, output rd,
		output ara_done, input rdata, input ara_armed);
	modport regs (input ptr, input wdata, input wr, input rd,
		input ara_done, output rdata, output ara_armed);
endinterface

// file: logic/tal_chan_cmp.sv
module tal_chan_cmp #(
	parameter int W = 8,
	parameter logic [W-1:0] HYST = tal_pkg::OVT_HYST
) (
	input wire logic [W-1:0] temp,
	input wire logic [W-1:0] high_lim,
	input wire logic [W-1:0] low_lim,
	input wire logic [W-1:0] ovt_lim,
	input wire logic ovt_now,
	input wire logic open_fault,
	output logic viol,
	output logic ovt_next
);
	// Window check, silenced by an open diode
	assign viol = !open_fault && (temp > high_lim || temp < low_lim);

	// Hysteresis band; extra bit keeps the sum from wrapping
	always_comb begin
		if (open_fault)
			ovt_next = 1'b0;
		else if (temp > ovt_lim)
			ovt_next = 1'b1;
		else if ({1'b0, temp} + {1'b0, HYST} < {1'b0, ovt_lim})
			ovt_next = 1'b0;
		else
			ovt_next = ovt_now;
	end
endmodule // tal_chan_cmp

// file: logic/tal_smb_slave.sv
module tal_smb_slave #(
	parameter logic [6:0] OWN_ADDR = 7'h2b
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic smb_clk,
	input wire logic smb_data_in,
	output logic smb_data_out,
	output logic smb_data_oe_n,
	tal_reg_if.smb bus
);
	typedef struct packed {
		tal_pkg::tal_smb_st_t st;
		logic [7:0] sr;
		logic [3:0] cnt;
		logic rw;
		logic ara;
		logic have_cmd;
		logic drive;
		logic scl;
		logic sda;
		logic wr;
		logic rd;
		logic done;
		logic [7:0] ptr;
		logic [7:0] wdata;
	} tal_smb_state_t;

	localparam tal_smb_state_t RST = '{st: tal_pkg::SMB_IDLE, sr: 8'h00,
		cnt: 4'h0, scl: 1'b1, sda: 1'b1, ptr: 8'h00, wdata: 8'h00,
		default: 1'b0};

	tal_smb_state_t q, d;
	logic rise, fall, start, stop, addr_hit, ara_hit;

	// Bus events from the previous sample
	assign rise = !q.scl && smb_clk;
	assign fall = q.scl && !smb_clk;
	assign start = q.scl && smb_clk && q.sda && !smb_data_in;
	assign stop = q.scl && smb_clk && !q.sda && smb_data_in;
	assign addr_hit = q.sr[7:1] == OWN_ADDR;
	// Only answer the alert response call while an alert is pending
	assign ara_hit = q.sr[7:1] == tal_pkg::ARA_ADDR && q.sr[0]
		&& bus.ara_armed;

	// Byte engine: shift on rising edge, drive on falling edge
	always_comb begin
		d = q;
		d.wr = 1'b0;
		d.rd = 1'b0;
		d.done = 1'b0;
		d.scl = smb_clk;
		d.sda = smb_data_in;
		if (start) begin
			d.st = tal_pkg::SMB_ADDR;
			d.cnt = 4'h0;
			d.drive = 1'b0;
		end else if (stop) begin
			d.st = tal_pkg::SMB_IDLE;
			d.drive = 1'b0;
			d.have_cmd = 1'b0;
		end else begin
			case (q.st)
				tal_pkg::SMB_ADDR: begin
					if (rise) begin
						d.sr = {q.sr[6:0], smb_data_in};
						d.cnt = q.cnt + 4'h1;
					end else if (fall && q.cnt == 4'h8) begin
						if (addr_hit || ara_hit) begin
							d.drive = 1'b1;
							d.rw = q.sr[0];
							d.ara = ara_hit && !addr_hit;
							d.st = tal_pkg::SMB_ACKA;
						end else
							d.st = tal_pkg::SMB_IDLE;
					end
				end
				tal_pkg::SMB_ACKA: begin
					if (fall) begin
						d.cnt = 4'h0;
						if (q.rw) begin
							d.sr = q.ara ? {OWN_ADDR, 1'b0} : bus.rdata;
							d.rd = !q.ara;
							d.drive = !d.sr[7];
							d.st = tal_pkg::SMB_TX;
						end else begin
							d.drive = 1'b0;
							d.st = tal_pkg::SMB_RX;
						end
					end
				end
				tal_pkg::SMB_RX: begin
					if (rise) begin
						d.sr = {q.sr[6:0], smb_data_in};
						d.cnt = q.cnt + 4'h1;
					end else if (fall && q.cnt == 4'h8) begin
						d.drive = 1'b1;
						d.st = tal_pkg::SMB_ACKR;
						if (q.have_cmd) begin
							d.wr = 1'b1;
							d.wdata = q.sr;
						end else begin
							d.ptr = q.sr;
							d.have_cmd = 1'b1;
						end
					end
				end
				tal_pkg::SMB_ACKR: begin
					if (fall) begin
						d.drive = 1'b0;
						d.cnt = 4'h0;
						d.st = tal_pkg::SMB_RX;
					end
				end
				tal_pkg::SMB_TX: begin
					if (rise) begin
						d.cnt = q.cnt + 4'h1;
						// Released a one but saw zero: lower address wins
						if (!q.drive && !smb_data_in)
							d.st = tal_pkg::SMB_IDLE;
					end else if (fall) begin
						if (q.cnt == 4'h8) begin
							d.drive = 1'b0;
							d.done = q.ara;
							d.st = tal_pkg::SMB_TXACK;
						end else begin
							d.sr = {q.sr[6:0], 1'b0};
							d.drive = !q.sr[6];
						end
					end
				end
				tal_pkg::SMB_TXACK: d.st = tal_pkg::SMB_TXACK;
				default: d.st = tal_pkg::SMB_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			q <= RST;
		else
			q <= d;
	end

	// Pull low only, never drive high
	assign smb_data_out = 1'b0;
	assign smb_data_oe_n = !q.drive;
	assign bus.ptr = q.ptr;
	assign bus.wdata = q.wdata;
	assign bus.wr = q.wr;
	assign bus.rd = q.rd;
	assign bus.ara_done = q.done;
endmodule // tal_smb_slave

// file: logic/tal_alarm_top.sv
module tal_alarm_top #(
	parameter int FAULT_CYC = tal_pkg::FAULT_CYC,
	// Slave address, value arbitrary
	parameter logic [6:0] OWN_ADDR = 7'h2b
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic smb_clk,
	input wire logic smb_data_in,
	output logic smb_data_out,
	output logic smb_data_oe_n,
	input wire logic alert_in,
	output logic alert_out,
	output logic alert_oe_n,
	input wire logic overt_in,
	output logic overt_out,
	output logic overt_oe_n,
	output logic afe_start,
	output logic [2:0] afe_chan,
	input wire logic afe_done,
	input wire logic [7:0] afe_temp,
	input wire logic [7:0] afe_ext,
	input wire logic diode_open,
	input wire logic diode_short
);
	localparam int FW = $clog2(FAULT_CYC + 1);
	localparam logic [FW-1:0] FAULT_LAST = FW'(FAULT_CYC - 1);
	localparam logic [2:0] LOCAL_CH = 3'(tal_pkg::IDX_LOCAL);
	localparam logic [2:0] R5_CH = 3'(tal_pkg::IDX_R5);
	localparam logic [2:0] R6_CH = 3'(tal_pkg::IDX_R6);

	typedef struct packed {
		tal_pkg::tal_seq_t seq;
		logic [2:0] chan;
		logic [FW-1:0] fcnt;
		logic [7:0][7:0] temp;
		logic [7:0][7:0] hi;
		logic [7:0][7:0] ovl;
		logic [7:0] lo;
		logic [7:0] cfg;
		logic [7:0] amask;
		logic [7:0] omask;
		logic [2:0][7:0] ext;
		logic [7:0] st_alert;
		logic [7:0] st_fault;
		logic [7:0] ovt;
		logic alert;
		logic ovt_pin;
		logic start;
	} tal_main_state_t;

	// Power-on values of every register
	localparam tal_main_state_t RST = '{
		seq: tal_pkg::SEQ_START,
		chan: 3'h0,
		fcnt: '0,
		temp: '0,
		hi: {8{tal_pkg::HIGH_RST}},
		ovl: {8{tal_pkg::OVT_RST}},
		lo: tal_pkg::LOW_RST,
		cfg: tal_pkg::CFG_RST,
		amask: tal_pkg::MASK_RST,
		omask: tal_pkg::MASK_RST,
		ext: {3{tal_pkg::EXT_RST}},
		st_alert: 8'h00,
		st_fault: 8'h00,
		ovt: 8'h00,
		alert: 1'b0,
		ovt_pin: 1'b0,
		start: 1'b0
	};

	tal_main_state_t q, d;
	tal_reg_if bus ();

	logic finish;
	logic fault;
	logic open_fault;
	logic [7:0] new_temp;
	logic viol;
	logic ovt_next;
	logic [7:0] rdata;
	logic diode_bad;

	// Two-wire slave feeding the register file
	tal_smb_slave #(
		.OWN_ADDR(OWN_ADDR)
	) u_smb (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.smb_clk(smb_clk),
		.smb_data_in(smb_data_in),
		.smb_data_out(smb_data_out),
		.smb_data_oe_n(smb_data_oe_n),
		.bus(bus)
	);

	// Limit check for the channel just converted
	tal_chan_cmp #(
		.W(8),
		.HYST(tal_pkg::OVT_HYST)
	) u_cmp (
		.temp(new_temp),
		.high_lim(q.hi[q.chan]),
		.low_lim(q.lo),
		.ovt_lim(q.ovl[q.chan]),
		.ovt_now(q.ovt[q.chan]),
		.open_fault(open_fault),
		.viol(viol),
		.ovt_next(ovt_next)
	);

	// Local sensor has no external diode to fault
	assign diode_bad = (diode_open || diode_short)
		&& q.chan != LOCAL_CH;

	// Conversion completion: normal result or a qualified diode fault
	always_comb begin
		finish = 1'b0;
		fault = 1'b0;
		new_temp = afe_temp;
		if (q.seq == tal_pkg::SEQ_WAIT) begin
			if (afe_done) begin
				finish = 1'b1;
			end else if (diode_bad && q.fcnt == FAULT_LAST) begin
				finish = 1'b1;
				fault = 1'b1;
				new_temp = tal_pkg::FAULT_TEMP;
			end
		end
	end

	// A shorted diode still runs the compare on FFh
	assign open_fault = fault && diode_open;

	// Register writes, clears, sequencer and alarm update
	always_comb begin
		d = q;
		d.start = 1'b0;

		// Host writes to limits and control
		if (bus.wr) begin
			if (bus.ptr[7:3] == tal_pkg::REG_HIGH_BASE[7:3])
				d.hi[bus.ptr[2:0]] = bus.wdata;
			else if (bus.ptr[7:3] == tal_pkg::REG_OVT_BASE[7:3])
				d.ovl[bus.ptr[2:0]] = bus.wdata;
			else begin
				case (bus.ptr)
					tal_pkg::REG_LOW: d.lo = bus.wdata;
					tal_pkg::REG_CONFIG: d.cfg = bus.wdata;
					tal_pkg::REG_ALERT_MASK: d.amask = bus.wdata;
					tal_pkg::REG_OVT_MASK: d.omask = bus.wdata;
					default: d.cfg = q.cfg;
				endcase
			end
		end

		// Clears go first so a same-cycle set wins
		if (bus.rd && bus.ptr == tal_pkg::REG_STAT_ALERT) begin
			d.st_alert = 8'h00;
			d.alert = 1'b0;
		end
		if (bus.rd && bus.ptr == tal_pkg::REG_STAT_FAULT)
			d.st_fault = 8'h00;
		if (bus.ara_done)
			d.alert = 1'b0;

		// Round robin; the alert latch has no say in it
		case (q.seq)
			tal_pkg::SEQ_START: begin
				if (!q.cfg[tal_pkg::CFG_STOP_BIT]) begin
					d.start = 1'b1;
					d.fcnt = '0;
					d.seq = tal_pkg::SEQ_WAIT;
				end
			end
			tal_pkg::SEQ_WAIT: begin
				if (finish) begin
					d.chan = q.chan + 3'h1;
					d.seq = tal_pkg::SEQ_START;
				end else if (diode_bad)
					d.fcnt = q.fcnt + FW'(1);
				else
					d.fcnt = '0;
			end
			default: d.seq = tal_pkg::SEQ_START;
		endcase

		// Result capture and alarm evaluation
		if (finish) begin
			d.temp[q.chan] = new_temp;
			d.ovt[q.chan] = ovt_next;
			if (fault)
				d.st_fault[q.chan] = 1'b1;
			if (viol) begin
				d.st_alert[q.chan] = 1'b1;
				if (!q.amask[q.chan])
					d.alert = 1'b1;
			end
			if (!fault) begin
				case (q.chan)
					R5_CH: d.ext[0] = afe_ext;
					R6_CH: d.ext[1] = afe_ext;
					LOCAL_CH: d.ext[2] = afe_ext;
					default: d.ext = q.ext;
				endcase
			end
		end

		// Overtemperature pin follows live state through its mask
		d.ovt_pin = |(d.ovt & ~d.omask);
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			q <= RST;
		else
			q <= d;
	end

	// Read mux; unmapped offsets read as zero
	always_comb begin
		rdata = 8'h00;
		if (bus.ptr[7:3] == tal_pkg::REG_TEMP_BASE[7:3])
			rdata = q.temp[bus.ptr[2:0]];
		else if (bus.ptr[7:3] == tal_pkg::REG_HIGH_BASE[7:3])
			rdata = q.hi[bus.ptr[2:0]];
		else if (bus.ptr[7:3] == tal_pkg::REG_OVT_BASE[7:3])
			rdata = q.ovl[bus.ptr[2:0]];
		else begin
			case (bus.ptr)
				tal_pkg::REG_LOW: rdata = q.lo;
				tal_pkg::REG_CONFIG: rdata = q.cfg;
				tal_pkg::REG_ALERT_MASK: rdata = q.amask;
				tal_pkg::REG_OVT_MASK: rdata = q.omask;
				tal_pkg::REG_STAT_ALERT: rdata = q.st_alert;
				tal_pkg::REG_STAT_OVT: rdata = q.ovt;
				tal_pkg::REG_STAT_FAULT: rdata = q.st_fault;
				tal_pkg::REG_EXT_R5: rdata = q.ext[0];
				tal_pkg::REG_EXT_R6: rdata = q.ext[1];
				tal_pkg::REG_EXT_LOCAL: rdata = q.ext[2];
				default: rdata = 8'h00;
			endcase
		end
	end

	assign bus.rdata = rdata;
	assign bus.ara_armed = q.alert;

	// Front end request; start is a one-cycle pulse
	assign afe_start = q.start;
	assign afe_chan = q.chan;

	// Open-drain alarm pins: low or released, line is shared
	assign alert_out = 1'b0;
	assign alert_oe_n = !q.alert;
	assign overt_out = 1'b0;
	assign overt_oe_n = !q.ovt_pin;
endmodule // tal_alarm_top

// file: sim/tal_alarm_checker.sv
module tal_alarm_checker #(
	parameter int FAULT_CYC = 20
) (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic alert_out,
	input wire logic alert_oe_n,
	input wire logic overt_out,
	input wire logic overt_oe_n,
	input wire logic smb_data_out,
	input wire logic afe_start,
	input wire logic [2:0] afe_chan,
	input wire logic afe_done,
	input wire logic diode_open,
	input wire logic diode_short
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	logic busy_q, seen_q;
	logic [2:0] last_q;
	int cnt_q;
	// Age of the conversion in flight; a faulty diode never ends it
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			busy_q <= 1'b0;
			seen_q <= 1'b0;
			last_q <= 3'h0;
			cnt_q <= 0;
		end else if (afe_start) begin
			busy_q <= 1'b1;
			seen_q <= 1'b1;
			last_q <= afe_chan;
			cnt_q <= 1;
		end else if (afe_done) begin
			busy_q <= 1'b0;
		end else if (busy_q) begin
			cnt_q <= cnt_q + 1;
		end
	end
	alert_od_a: assert property (alert_out == 1'b0)
		else $error("alert pin driven high");
	// The other open-drain pins may only pull low as well
	pins_od_a: assert property (overt_out == 1'b0 && smb_data_out == 1'b0)
		else $error("open-drain pin driven high");
	alert_cause_a: assert property ($fell(alert_oe_n) |->
		$past(afe_done) || $past(diode_short))
		else $error("alert without completion");
	open_quiet_a: assert property ($fell(alert_oe_n) |->
		!$past(diode_open)) else $error("open diode alerted");
	ovt_quiet_a: assert property ($fell(overt_oe_n) |->
		!$past(diode_open)) else $error("open diode overtemp");
	ovt_cause_a: assert property ($fell(overt_oe_n) |->
		$past(afe_done) || $past(diode_short))
		else $error("overtemp without completion");
	start_pulse_a: assert property (afe_start |=> !afe_start)
		else $error("start longer than a cycle");
	next_chan_a: assert property (afe_start && seen_q |->
		afe_chan == last_q + 3'h1) else $error("channel order broken");
	keep_going_a: assert property (afe_done |-> ##[1:8] afe_start)
		else $error("sequence stalled");
	fault_wait_a: assert property (afe_start && busy_q |->
		cnt_q >= FAULT_CYC) else $error("fault declared early");
	fault_bound_a: assert property (busy_q && (diode_open ||
		diode_short) |-> cnt_q <= FAULT_CYC + 8)
		else $error("fault never declared");
	cover property ($fell(alert_oe_n));
	cover property ($fell(overt_oe_n));
	cover property (afe_start && busy_q);
endmodule // tal_alarm_checker
bind tal_alarm_top tal_alarm_checker #(.FAULT_CYC(FAULT_CYC)) i_chk (
	.sys_clk(sys_clk), .rstn(rstn), .alert_out(alert_out),
	.alert_oe_n(alert_oe_n), .overt_out(overt_out),
	.overt_oe_n(overt_oe_n), .smb_data_out(smb_data_out),
	.afe_start(afe_start), .afe_chan(afe_chan), .afe_done(afe_done),
	.diode_open(diode_open), .diode_short(diode_short));

// file: sim/tal_fe_model.sv
module tal_fe_model (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic afe_start,
	input wire logic [2:0] afe_chan,
	input wire logic [7:0][7:0] temps,
	input wire logic [7:0] opn,
	input wire logic [7:0] sht,
	input wire logic [31:0] dly,
	output logic afe_done,
	output logic [7:0] afe_temp,
	output logic [7:0] afe_ext,
	output logic diode_open,
	output logic diode_short
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy_q;
	logic [2:0] ch_q;
	logic [31:0] cnt_q;
	logic flt;
	// Diode levels only while that channel converts
	assign flt = opn[ch_q] | sht[ch_q];
	assign diode_open = busy_q & opn[ch_q];
	assign diode_short = busy_q & sht[ch_q];
	// Delay read live, so the bench can freeze a conversion; data toggles
	// outside the done cycle so a late sample shows up
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			busy_q <= 1'b0;
			ch_q <= 3'h0;
			cnt_q <= 32'h0000_0000;
			afe_done <= 1'b0;
			afe_temp <= 8'h00;
			afe_ext <= 8'h00;
		end else begin
			afe_done <= 1'b0;
			afe_temp <= ~afe_temp;
			afe_ext <= ~afe_ext;
			if (afe_start) begin
				busy_q <= 1'b1;
				ch_q <= afe_chan;
				cnt_q <= 32'h0000_0000;
			end else if (busy_q && !flt) begin
				cnt_q <= cnt_q + 32'h0000_0001;
				if (cnt_q >= dly) begin
					busy_q <= 1'b0;
					afe_done <= 1'b1;
					afe_temp <= temps[ch_q];
					// Extended bits made distinct from the reset value
					afe_ext <= temps[ch_q] ^ 8'ha5;
				end
			end
		end
	end
endmodule // tal_fe_model

// file: sim/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FC = 20; // Short fault time keeps the run brief
	localparam int Q = 3; // Third of a bus bit, in clocks
	localparam logic [6:0] DA = 7'h2b; // Bus address, value arbitrary
	localparam logic [7:0] SA = tal_pkg::REG_STAT_ALERT;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic scl = 1'b1;
	logic sda = 1'b1;
	logic smb_data_oe_n, alert_oe_n, overt_oe_n, afe_start, afe_done;
	logic diode_open, diode_short;
	logic [2:0] afe_chan;
	logic [7:0] afe_temp, afe_ext;
	logic [7:0] opn = 8'h00;
	logic [7:0] sht = 8'h00;
	logic [7:0][7:0] tmp = {8{8'h30}};
	logic [31:0] dly = 32'h0001_86a0; // Front end frozen until released
	int fail_count = 0;
	int total_checks = 0;
	wire logic sdaw = sda & smb_data_oe_n; // Pulled-up data wire
	tal_alarm_top #(.FAULT_CYC(FC), .OWN_ADDR(DA)) i_tal_alarm_top (
		.sys_clk(sys_clk), .rstn(rstn), .smb_clk(scl), .smb_data_in(sdaw),
		.smb_data_out(), .smb_data_oe_n(smb_data_oe_n),
		.alert_in(alert_oe_n), .alert_out(), .alert_oe_n(alert_oe_n),
		.overt_in(overt_oe_n), .overt_out(), .overt_oe_n(overt_oe_n),
		.afe_start(afe_start), .afe_chan(afe_chan), .afe_done(afe_done),
		.afe_temp(afe_temp), .afe_ext(afe_ext), .diode_open(diode_open),
		.diode_short(diode_short));
	tal_fe_model i_tal_fe_model (.sys_clk(sys_clk), .rstn(rstn),
		.afe_start(afe_start), .afe_chan(afe_chan), .temps(tmp),
		.opn(opn), .sht(sht), .dly(dly), .afe_done(afe_done),
		.afe_temp(afe_temp), .afe_ext(afe_ext),
		.diode_open(diode_open), .diode_short(diode_short));
	initial begin
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e,
		input string m);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %0t %s got %h want %h", $time, m, g, e);
		end
	endtask
	// Inputs move 1 ns after the edge, clear of sampling
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wsig(input logic ov, input logic v);
		for (int n = 0; n < 2000; n++) begin
			if ((ov ? overt_oe_n : alert_oe_n) === v) break;
			cyc(1);
		end
		chk({7'h00, ov ? overt_oe_n : alert_oe_n}, {7'h00, v}, "alarm");
		if ((ov ? overt_oe_n : alert_oe_n) !== v) wrap_up();
	endtask
	// Sixteen completions: at least two full rounds
	task automatic rnd();
		int k = 0;
		for (int n = 0; n < 4000 && k < 16; n++) begin
			cyc(1);
			if (afe_done === 1'b1) k++;
		end
		chk(8'(k), 8'h10, "conversions stalled");
		if (k < 16) wrap_up();
	endtask
	task automatic bt(input logic b, output logic r);
		sda = b;
		cyc(Q);
		scl = 1'b1;
		cyc(Q);
		r = sdaw;
		scl = 1'b0;
		cyc(Q);
	endtask
	task automatic st();
		sda = 1'b1;
		cyc(Q);
		scl = 1'b1;
		cyc(Q);
		sda = 1'b0;
		cyc(Q);
		scl = 1'b0;
	endtask
	task automatic sp();
		sda = 1'b0;
		cyc(Q);
		scl = 1'b1;
		cyc(Q);
		sda = 1'b1;
		cyc(Q);
	endtask
	task automatic wb(input logic [7:0] v, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) bt(v[i], r);
		bt(1'b1, r);
		a = (r === 1'b0);
	endtask
	task automatic rb(output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bt(1'b1, r);
			v[i] = r;
		end
		bt(1'b1, r); // No acknowledge ends the read
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic a0, a1, a2;
		st();
		wb({DA, 1'b0}, a0);
		wb(p, a1);
		wb(d, a2);
		sp();
		chk({5'h00, a0, a1, a2}, 8'h07, "write ack");
	endtask
	task automatic rd(input logic [7:0] p, output logic [7:0] d);
		logic a0, a1, a2;
		st();
		wb({DA, 1'b0}, a0);
		wb(p, a1);
		st();
		wb({DA, 1'b1}, a2);
		rb(d);
		sp();
		chk({5'h00, a0, a1, a2}, 8'h07, "read ack");
	endtask
	task automatic ara(output logic [7:0] d, output logic a);
		st();
		wb({tal_pkg::ARA_ADDR, 1'b1}, a);
		rb(d);
		sp();
	endtask
	task automatic t_regs();
		logic [7:0] p, v;
		// Front end still frozen, so the extended bits hold reset
		for (int i = 0; i < 3; i++) begin
			rd(8'h55 + 8'(i), v);
			chk(v, tal_pkg::EXT_RST, "ext reset");
		end
		dly = 32'h0000_0003;
		for (int i = 0; i < 17; i++) begin
			p = i < 8 ? 8'h10 + 8'(i) : i == 8 ? 8'h18 : 8'h17 + 8'(i);
			rd(p, v);
			chk(v, i < 8 ? tal_pkg::HIGH_RST : i == 8 ? tal_pkg::LOW_RST
				: tal_pkg::OVT_RST, "limit reset");
			wr(p, 8'h40 + 8'(i));
			rd(p, v);
			chk(v, 8'h40 + 8'(i), "limit rw");
		end
		rd(tal_pkg::REG_ALERT_MASK, v);
		chk(v, 8'h00, "mask reset");
		// Captured bits are the model's temperature xor a5, not the write
		for (int i = 0; i < 3; i++) begin
			wr(8'h55 + 8'(i), 8'hff);
			rd(8'h55 + 8'(i), v);
			chk(v, 8'h30 ^ 8'ha5, "ext read only");
		end
		wr(8'h18, 8'h20);
		// Drop status and latch left by the wide low limit
		rd(SA, v);
		$display("register test done");
	endtask
	task automatic t_alert(input int c, input logic [7:0] t);
		logic [7:0] v, b;
		b = 8'h01 << c;
		tmp[c] = t;
		wsig(1'b0, 1'b0);
		dly = 32'h0001_86a0; // Freeze the front end over the read
		rd(SA, v);
		chk(v & b, b, "status bit");
		chk({7'h00, alert_oe_n}, 8'h01, "read clear");
		dly = 32'h0000_0003;
		wsig(1'b0, 1'b0);
		wr(tal_pkg::REG_ALERT_MASK, b);
		rd(SA, v);
		rnd();
		chk({7'h00, alert_oe_n}, 8'h01, "masked");
		wr(tal_pkg::REG_ALERT_MASK, 8'h00);
		wsig(1'b0, 1'b0);
		tmp[c] = 8'h30;
		rnd();
		chk({7'h00, alert_oe_n}, 8'h00, "latch held");
		rd(SA, v);
		rnd();
		chk({7'h00, alert_oe_n}, 8'h01, "released");
		$display("alert test done on channel %0d", c);
	endtask
	task automatic t_ara();
		logic [7:0] v;
		logic a;
		tmp[2] = 8'h60;
		wsig(1'b0, 1'b0);
		tmp[2] = 8'h30;
		rnd();
		ara(v, a);
		chk({7'h00, a}, 8'h01, "response ack");
		chk(v >> 1, {1'b0, DA}, "response address");
		chk({7'h00, alert_oe_n}, 8'h01, "response clear");
		ara(v, a);
		chk({7'h00, a}, 8'h00, "idle response");
		$display("alert response test done");
	endtask
	task automatic t_ovt();
		wr(tal_pkg::REG_OVT_BASE, 8'h60);
		tmp[0] = 8'h60;
		rnd();
		chk({7'h00, overt_oe_n}, 8'h01, "equal limit");
		tmp[0] = 8'h61;
		wsig(1'b1, 1'b0);
		tmp[0] = 8'h5d;
		rnd();
		chk({7'h00, overt_oe_n}, 8'h00, "hysteresis");
		tmp[0] = 8'h5b;
		wsig(1'b1, 1'b1);
		tmp[0] = 8'h30;
		$display("overtemperature test done");
	endtask
	task automatic t_fault();
		logic [7:0] v;
		opn[1] = 1'b1;
		tmp[1] = 8'h70;
		rnd();
		rd(SA, v);
		rnd();
		chk({6'h00, alert_oe_n, overt_oe_n}, 8'h03, "open quiet");
		rd(tal_pkg::REG_TEMP_BASE + 8'h01, v);
		chk(v, tal_pkg::FAULT_TEMP, "open temp");
		rd(tal_pkg::REG_STAT_FAULT, v);
		chk(v & 8'h02, 8'h02, "open fault bit");
		opn[1] = 1'b0;
		sht[3] = 1'b1;
		rnd();
		rd(tal_pkg::REG_STAT_FAULT, v);
		chk(v & 8'h08, 8'h08, "short fault bit");
		rd(tal_pkg::REG_TEMP_BASE + 8'h03, v);
		chk(v, tal_pkg::FAULT_TEMP, "short temp");
		sht[3] = 1'b0;
		tmp[1] = 8'h30;
		$display("diode fault test done");
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		#1;
		rstn = 1'b1;
		cyc(2);
		t_regs();
		t_alert(2, 8'h60);
		t_alert(6, 8'h10);
		t_ara();
		t_ovt();
		t_fault();
		wrap_up();
	end
endmodule // tb_top
